// *** logic/fmio_pkg.sv ***
package fmio_pkg;

    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_S;

    localparam int unsigned PULSE_MIN_MS    = 50;
    localparam int unsigned PULSE_MAX_MS    = 500;
    localparam int unsigned PULSE_PERIOD_MS = 100;
    localparam int unsigned LONG_PRESS_S    = 6;
    localparam int unsigned IDLE_EXIT_S     = 60;
    localparam int unsigned DEBOUNCE_MS     = 20;
    localparam int unsigned SELFTEST_MS     = 10;
    localparam int unsigned BANNER_MS       = 1000;

    localparam int unsigned LONG_PRESS_CYC  = LONG_PRESS_S * CLK_HZ;
    localparam int unsigned IDLE_EXIT_CYC   = IDLE_EXIT_S * CLK_HZ;
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CYC_PER_MS;
    localparam int unsigned BANNER_CYC      = BANNER_MS * CYC_PER_MS;
    localparam int unsigned SELFTEST_CYC    = SELFTEST_MS * CYC_PER_MS;

    localparam logic [1:0]  BIN_NONE        = 2'h0;
    localparam logic [1:0]  BIN_START       = 2'h1;
    localparam logic [1:0]  BIN_STOP        = 2'h2;
    localparam logic [1:0]  BIN_RESET       = 2'h3;

    localparam logic [15:0] LOOP_4MA        = 16'h0FA0;
    localparam logic [15:0] LOOP_20MA       = 16'h4E20;
    localparam logic [7:0]  FW_VERSION      = 8'h10;

    typedef enum logic [4:0] {
        ST_INIT    = 5'h01,
        ST_CHECK   = 5'h02,
        ST_MEASURE = 5'h04,
        ST_LOOP    = 5'h08,
        ST_FAULT   = 5'h10
    } fmio_state_t;

endpackage : fmio_pkg

// *** logic/fmio_pulse.sv ***
`timescale 1ns/10ps
module fmio_pulse
    import fmio_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        pulse_mode,
    input  wire logic        normally_open,
    input  wire logic        limit_reached,
    input  wire logic        count_req,
    input  wire logic [8:0]  width_ms,
    output logic             pin_q
);

    logic [14:0] ms_cnt_q;
    logic        ms_tick;
    logic [8:0]  on_cnt_q;
    logic [9:0]  gap_cnt_q;
    logic [8:0]  width_eff;
    logic        pulse_on_q;
    logic        pulse_active;

    assign ms_tick   = (ms_cnt_q == 15'(CYC_PER_MS - 1));
    assign width_eff = (width_ms < 9'(PULSE_MIN_MS)) ? 9'(PULSE_MIN_MS) :
                       (width_ms > 9'(PULSE_MAX_MS)) ? 9'(PULSE_MAX_MS) : width_ms;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_q <= 15'h0000;
        end else if (ms_tick) begin
            ms_cnt_q <= 15'h0000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 15'h0001;
        end
    end

    // Pulse starts only when the period since the last start has elapsed.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_on_q <= 1'b0;
            on_cnt_q   <= 9'h000;
            gap_cnt_q  <= 10'h000;
        end else begin
            if (pulse_mode && !pulse_on_q && count_req && gap_cnt_q == 10'h000) begin
                pulse_on_q <= 1'b1;
                on_cnt_q   <= width_eff;
                gap_cnt_q  <= (width_eff > 9'(PULSE_PERIOD_MS)) ? {width_eff, 1'b0}
                              : 10'(PULSE_PERIOD_MS);
            end else if (ms_tick) begin
                if (on_cnt_q != 9'h000) begin
                    on_cnt_q <= on_cnt_q - 9'h001;
                end
                if (on_cnt_q == 9'h001) begin
                    pulse_on_q <= 1'b0;
                end
                if (gap_cnt_q != 10'h000) begin
                    gap_cnt_q <= gap_cnt_q - 10'h001;
                end
            end
        end
    end

    assign pulse_active = pulse_mode ? pulse_on_q : limit_reached;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= normally_open ? pulse_active : !pulse_active;
        end
    end

endmodule : fmio_pulse

// *** logic/fmio_top.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - Normally closed outputs go low on reached condition, normally open go high.
// - Each binary output can be switched to pulse mode.
// - Pulse width 50 to 500 ms, at most ten pulses per second.
// - Binary input starts, stops or resets the counter; polarity selectable.
// - Binary input ignored after reset until enabled.
// - Power-up shows init and version, checks parameters, then measures, or flags a fault if parameters are not plausible.
// - Button held over six seconds in measuring enters loop check at 4 mA.
// - In loop check a short press toggles between 4 and 20 mA.
// - In loop check a six-second hold returns to measured value.
// - Sixty seconds without a press leaves loop check by itself.
module fmio_top
    import fmio_pkg::*;
#(
    parameter int unsigned LONG_CYC   = LONG_PRESS_CYC,
    parameter int unsigned IDLE_CYC   = IDLE_EXIT_CYC,
    parameter int unsigned DEB_CYC    = DEBOUNCE_CYC,
    parameter int unsigned BANNER_LEN = BANNER_CYC,
    parameter int unsigned CHECK_LEN  = SELFTEST_CYC
)(
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic        LOOP_BUTTON,
    input  wire logic        BINARY_INPUT,
    input  wire logic        BIN_ENABLE,
    input  wire logic        BIN_ACTIVE_HIGH,
    input  wire logic [1:0]  BIN_FUNCTION,
    input  wire logic        PARAMS_PLAUSIBLE,
    input  wire logic [15:0] MEASURED_LOOP,
    input  wire logic        FLOW_INCREMENT,
    input  wire logic        LIMIT1_REACHED,
    input  wire logic        LIMIT2_REACHED,
    input  wire logic [1:0]  PULSE_MODE,
    input  wire logic [1:0]  NORMALLY_OPEN,
    input  wire logic [8:0]  PULSE_WIDTH_MS,
    output logic             FIRST_BINARY_OUTPUT,
    output logic             SECOND_BINARY_OUTPUT,
    output logic [15:0]      LOOP_CURRENT,
    output logic             SHOW_INIT,
    output logic [7:0]       SHOW_VERSION,
    output logic             MEASURING,
    output logic             LOOP_CHECK,
    output logic             PARAM_FAULT,
    output logic             COUNTER_RUN,
    output logic [31:0]      FLOW_COUNT
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers.

    logic       rst_meta_q, rst_n;
    logic [1:0] btn_sync_q, bin_sync_q;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            btn_sync_q <= 2'h0;
            bin_sync_q <= 2'h0;
        end else begin
            btn_sync_q <= {btn_sync_q[0], LOOP_BUTTON};
            bin_sync_q <= {bin_sync_q[0], BINARY_INPUT};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Button debounce and press timing.

    logic [19:0] deb_cnt_q;
    logic        btn_q;
    logic [31:0] press_cnt_q;
    logic        long_fired_q;
    logic        long_evt, short_evt, btn_rise;
    logic        btn_prev_q;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            deb_cnt_q <= 20'h00000;
            btn_q     <= 1'b0;
        end else if (btn_sync_q[1] == btn_q) begin
            deb_cnt_q <= 20'h00000;
        end else if (deb_cnt_q >= 20'(DEB_CYC - 1)) begin
            deb_cnt_q <= 20'h00000;
            btn_q     <= btn_sync_q[1];
        end else begin
            deb_cnt_q <= deb_cnt_q + 20'h00001;
        end
    end

    assign long_evt  = btn_q && !long_fired_q && press_cnt_q == 32'(LONG_CYC);
    assign short_evt = !btn_q && btn_prev_q && !long_fired_q;
    assign btn_rise  = btn_q && !btn_prev_q;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            press_cnt_q  <= 32'h00000000;
            long_fired_q <= 1'b0;
            btn_prev_q   <= 1'b0;
        end else begin
            btn_prev_q <= btn_q;
            if (!btn_q) begin
                press_cnt_q  <= 32'h00000000;
                long_fired_q <= 1'b0;
            end else begin
                if (press_cnt_q != 32'hFFFFFFFF) begin
                    press_cnt_q <= press_cnt_q + 32'h00000001;
                end
                if (long_evt) begin
                    long_fired_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operating state sequence.

    fmio_state_t state_q;
    logic [31:0] seq_cnt_q;
    logic        level_20_q;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_INIT;
            seq_cnt_q  <= 32'h00000000;
            level_20_q <= 1'b0;
        end else begin
            seq_cnt_q <= seq_cnt_q + 32'h00000001;
            case (state_q)
                ST_INIT: begin
                    if (seq_cnt_q >= 32'(BANNER_LEN - 1)) begin
                        state_q   <= ST_CHECK;
                        seq_cnt_q <= 32'h00000000;
                    end
                end
                ST_CHECK: begin
                    if (seq_cnt_q >= 32'(CHECK_LEN - 1)) begin
                        state_q   <= PARAMS_PLAUSIBLE ? ST_MEASURE : ST_FAULT;
                        seq_cnt_q <= 32'h00000000;
                    end
                end
                ST_MEASURE: begin
                    if (long_evt) begin
                        state_q    <= ST_LOOP;
                        level_20_q <= 1'b0;
                        seq_cnt_q  <= 32'h00000000;
                    end
                end
                ST_LOOP: begin
                    if (btn_rise || btn_q) begin
                        seq_cnt_q <= 32'h00000000;
                    end
                    if (long_evt) begin
                        state_q <= ST_MEASURE;
                    end else if (short_evt) begin
                        level_20_q <= !level_20_q;
                    end else if (!btn_q && seq_cnt_q >= 32'(IDLE_CYC)) begin
                        state_q <= ST_MEASURE;
                    end
                end
                ST_FAULT: begin
                    seq_cnt_q <= 32'h00000000;
                end
                default: begin
                    state_q <= ST_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            LOOP_CURRENT <= LOOP_4MA;
            SHOW_INIT    <= 1'b1;
            SHOW_VERSION <= 8'h00;
            MEASURING    <= 1'b0;
            LOOP_CHECK   <= 1'b0;
            PARAM_FAULT  <= 1'b0;
        end else begin
            SHOW_INIT    <= (state_q == ST_INIT);
            SHOW_VERSION <= (state_q == ST_INIT) ? FW_VERSION : 8'h00;
            MEASURING    <= (state_q == ST_MEASURE);
            LOOP_CHECK   <= (state_q == ST_LOOP);
            PARAM_FAULT  <= (state_q == ST_FAULT);
            if (state_q == ST_LOOP) begin
                LOOP_CURRENT <= level_20_q ? LOOP_20MA : LOOP_4MA;
            end else begin
                LOOP_CURRENT <= MEASURED_LOOP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Binary input and flow counter.

    logic bin_lvl, bin_prev_q, bin_edge;

    assign bin_lvl  = BIN_ACTIVE_HIGH ? bin_sync_q[1] : !bin_sync_q[1];
    assign bin_edge = bin_lvl && !bin_prev_q && BIN_ENABLE;

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bin_prev_q  <= 1'b1;
            COUNTER_RUN <= 1'b1;
            FLOW_COUNT  <= 32'h00000000;
        end else begin
            bin_prev_q <= bin_lvl;
            if (bin_edge && BIN_FUNCTION == BIN_RESET) begin
                FLOW_COUNT <= 32'h00000000;
            end else if (COUNTER_RUN && FLOW_INCREMENT) begin
                FLOW_COUNT <= FLOW_COUNT + 32'h00000001;
            end
            if (bin_edge && BIN_FUNCTION == BIN_START) begin
                COUNTER_RUN <= 1'b1;
            end else if (bin_edge && BIN_FUNCTION == BIN_STOP) begin
                COUNTER_RUN <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Binary outputs.

    logic cnt_req;

    assign cnt_req = COUNTER_RUN && FLOW_INCREMENT;

    fmio_pulse u_out1 (
        .clk           (CORE_CLK),
        .rst_n         (rst_n),
        .pulse_mode    (PULSE_MODE[0]),
        .normally_open (NORMALLY_OPEN[0]),
        .limit_reached (LIMIT1_REACHED),
        .count_req     (cnt_req),
        .width_ms      (PULSE_WIDTH_MS),
        .pin_q         (FIRST_BINARY_OUTPUT)
    );

    fmio_pulse u_out2 (
        .clk           (CORE_CLK),
        .rst_n         (rst_n),
        .pulse_mode    (PULSE_MODE[1]),
        .normally_open (NORMALLY_OPEN[1]),
        .limit_reached (LIMIT2_REACHED),
        .count_req     (cnt_req),
        .width_ms      (PULSE_WIDTH_MS),
        .pin_q         (SECOND_BINARY_OUTPUT)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_enter_loop;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (state_q == ST_MEASURE && long_evt) |=> state_q == ST_LOOP ##1 LOOP_CURRENT == LOOP_4MA;
    endproperty
    a_enter_loop: assert property (p_enter_loop) else $error("Loop entry failed.");

    property p_toggle;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (state_q == ST_LOOP && short_evt) |=> level_20_q != $past(level_20_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("Short press did not toggle.");

    property p_exit_loop;
        @(posedge CORE_CLK) disable iff (!rst_n)
        (state_q == ST_LOOP && long_evt) |=> state_q == ST_MEASURE;
    endproperty
    a_exit_loop: assert property (p_exit_loop) else $error("Loop exit failed.");

    property p_bin_disabled;
        @(posedge CORE_CLK) disable iff (!rst_n)
        !BIN_ENABLE |=> $stable(COUNTER_RUN);
    endproperty
    a_bin_disabled: assert property (p_bin_disabled) else $error("Input acted while off.");

    property p_measure_after_check;
        @(posedge CORE_CLK) disable iff (!rst_n)
        $rose(MEASURING) && !$past(LOOP_CHECK) |-> $past(state_q, 2) == ST_CHECK;
    endproperty
    a_measure_after_check: assert property (p_measure_after_check) else $error("Bad start.");

    logic [31:0] idle_cnt_q;

    // Counts released-button cycles in loop check, apart from the sequencer.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_q <= 32'h00000000;
        end else if (state_q != ST_LOOP || btn_q) begin
            idle_cnt_q <= 32'h00000000;
        end else if (idle_cnt_q != 32'hFFFFFFFF) begin
            idle_cnt_q <= idle_cnt_q + 32'h00000001;
        end
    end

    property p_idle_exit;
        @(posedge CORE_CLK) disable iff (!rst_n)
        state_q == ST_LOOP |-> idle_cnt_q <= 32'(IDLE_CYC);
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("Idle exit late.");

    cover property (@(posedge CORE_CLK) disable iff (!rst_n) state_q == ST_LOOP && short_evt);
    cover property (@(posedge CORE_CLK) disable iff (!rst_n) $rose(MEASURING));
    cover property (@(posedge CORE_CLK) disable iff (!rst_n) bin_edge);

endmodule : fmio_top

// *** testbench/fmio_amp_model.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Switching amplifier on the far side; it only listens to the two output lines.
module fmio_amp_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       line_a,
    input  wire logic       line_b,
    output logic      [7:0] rises_a,
    output logic      [7:0] rises_b
);
    logic prev_a_q;
    logic prev_b_q;

    // Counts each rising edge of a line, as a counting input would.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_a_q <= 1'b0;
            prev_b_q <= 1'b0;
            rises_a  <= 8'h00;
            rises_b  <= 8'h00;
        end else begin
            prev_a_q <= line_a;
            prev_b_q <= line_b;
            if (line_a && !prev_a_q) begin
                rises_a <= rises_a + 8'h01;
            end
            if (line_b && !prev_b_q) begin
                rises_b <= rises_b + 8'h01;
            end
        end
    end
endmodule : fmio_amp_model

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top
    import fmio_pkg::*;
;
    logic        clk, rst_n, btn, bin_in, bin_en, bin_hi, plaus, flow, lim1, lim2;
    logic [1:0]  bin_fn, pmode, nopen;
    logic [15:0] meas, loop_i;
    logic [8:0]  pw;
    logic        out1, out2, init_s, meas_s, loop_s, fault, run;
    logic [7:0]  ver, ra, rb, ra0, rb0;
    logic [31:0] cnt;
    int          n_fail, checks_done, cyc;

    fmio_top #(.LONG_CYC(200), .IDLE_CYC(2000), .DEB_CYC(4), .BANNER_LEN(10),
               .CHECK_LEN(10)) dut (
        .CORE_CLK(clk), .RESET_N(rst_n), .LOOP_BUTTON(btn), .BINARY_INPUT(bin_in),
        .BIN_ENABLE(bin_en), .BIN_ACTIVE_HIGH(bin_hi), .BIN_FUNCTION(bin_fn),
        .PARAMS_PLAUSIBLE(plaus), .MEASURED_LOOP(meas), .FLOW_INCREMENT(flow),
        .LIMIT1_REACHED(lim1), .LIMIT2_REACHED(lim2), .PULSE_MODE(pmode),
        .NORMALLY_OPEN(nopen), .PULSE_WIDTH_MS(pw), .FIRST_BINARY_OUTPUT(out1),
        .SECOND_BINARY_OUTPUT(out2), .LOOP_CURRENT(loop_i), .SHOW_INIT(init_s),
        .SHOW_VERSION(ver), .MEASURING(meas_s), .LOOP_CHECK(loop_s),
        .PARAM_FAULT(fault), .COUNTER_RUN(run), .FLOW_COUNT(cnt));

    fmio_amp_model amp (.clk(clk), .rst_n(rst_n), .line_a(out1), .line_b(out2),
                        .rises_a(ra), .rises_b(rb));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wait_cyc

    task automatic press(input int n);
        @(posedge clk);
        btn <= 1'b1;
        repeat (n) @(posedge clk);
        btn <= 1'b0;
        wait_cyc(20);
    endtask : press

    task automatic bin_act(input logic [1:0] fn);
        @(posedge clk);
        bin_fn <= fn;
        bin_in <= bin_hi;
        wait_cyc(10);
        @(posedge clk);
        bin_in <= ~bin_hi;
        wait_cyc(10);
    endtask : bin_act

    task automatic flow_pulse;
        @(posedge clk);
        flow <= 1'b1;
        @(posedge clk);
        flow <= 1'b0;
    endtask : flow_pulse

    task automatic complete_run;
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_power;
        wait_cyc(5);
        check(init_s, 1);
        check(meas_s, 0);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_cyc(6);
        check(init_s, 1);
        check(ver, FW_VERSION);
        check(meas_s, 0);
        wait_cyc(40);
        check(meas_s, 1);
        check(init_s, 0);
        check(fault, 0);
    endtask : t_power

    task automatic t_switch;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            nopen <= i[1] ? 2'b11 : 2'b00;
            lim1  <= i[0];
            lim2  <= ~i[0];
            wait_cyc(5);
            check(out1, 1'(~(i[1] ^ i[0])));
            check(out2, 1'(i[1] ^ i[0]));
        end
    endtask : t_switch

    task automatic t_binary;
        bin_act(BIN_STOP);
        check(run, 1);
        repeat (3) flow_pulse;
        wait_cyc(4);
        check(cnt, 3);
        @(posedge clk);
        bin_en <= 1'b1;
        bin_act(BIN_RESET);
        check(cnt, 0);
        repeat (2) flow_pulse;
        bin_act(BIN_STOP);
        check(run, 0);
        flow_pulse;
        wait_cyc(4);
        check(cnt, 2);
        @(posedge clk);
        bin_hi <= 1'b0;
        bin_in <= 1'b1;
        wait_cyc(5);
        bin_act(BIN_NONE);
        check(run, 0);
        bin_act(BIN_START);
        check(run, 1);
    endtask : t_binary

    task automatic t_loop;
        @(posedge clk);
        meas <= 16'h1234;
        press(30);
        check(loop_s, 0);
        check(loop_i, 16'h1234);
        press(500);
        check(loop_s, 1);
        check(loop_i, LOOP_4MA);
        press(30);
        check(loop_i, LOOP_20MA);
        press(30);
        check(loop_i, LOOP_4MA);
        press(30);
        check(loop_i, LOOP_20MA);
        press(500);
        check(loop_s, 0);
        check(loop_i, 16'h1234);
        check(meas_s, 1);
        press(230);
        check(loop_s, 1);
        wait_cyc(1900);
        check(loop_s, 1);
        wait_cyc(200);
        check(loop_s, 0);
        check(loop_i, 16'h1234);
    endtask : t_loop

    task automatic t_pulse;
        @(posedge clk);
        pw    <= 9'h032;
        pmode <= 2'b11;
        nopen <= 2'b11;
        lim1  <= 1'b0;
        lim2  <= 1'b0;
        wait_cyc(5);
        check(out1, 0);
        check(out2, 0);
        ra0 = ra;
        rb0 = rb;
        flow_pulse;
        wait_cyc(5);
        check(out1, 1);
        check(out2, 1);
        flow_pulse;
        wait_cyc(1500);
        check(out1, 1);
        check(ra, ra0 + 8'h01);
        check(rb, rb0 + 8'h01);
    endtask : t_pulse

    task automatic t_fault;
        @(posedge clk);
        plaus <= 1'b0;
        rst_n <= 1'b0;
        wait_cyc(3);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_cyc(40);
        check(fault, 1);
        check(meas_s, 0);
    endtask : t_fault

    ////////////////////////////////////////////////////////////////////////////
    // Clock, timeout and main sequence.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run;
        end
    end

    initial begin
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        rst_n = 1'b0;
        btn = 1'b0;
        bin_in = 1'b0;
        bin_en = 1'b0;
        bin_hi = 1'b1;
        bin_fn = BIN_NONE;
        plaus = 1'b1;
        flow = 1'b0;
        lim1 = 1'b0;
        lim2 = 1'b0;
        pmode = 2'b00;
        nopen = 2'b00;
        pw = 9'h032;
        meas = 16'h0000;
        t_power;
        t_switch;
        t_binary;
        t_loop;
        t_pulse;
        t_fault;
        complete_run;
    end
endmodule : tb_top
